/* File: rtl/ali_pkg.sv */
package ali_pkg;

    // ------------------------------------------------------------
    // angle and coefficient formats
    // ------------------------------------------------------------
    // one revolution is 2**15 angle steps, so one coefficient step
    // equals one angle step at the normal correction range
    localparam int ANGLE_W = 15;
    localparam int COEF_W = 12;
    localparam int NUM_COEF = 32;
    localparam int SEG_W = 5;
    localparam int FRAC_W = 10;
    localparam int CORR_W = 14;

    // ------------------------------------------------------------
    // register port
    // ------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 16;
    localparam logic [5:0] REG_COEF_BASE = 6'h00;
    localparam logic [5:0] REG_COEF_LAST = 6'h1f;
    localparam logic [5:0] REG_CTRL = 6'h20;
    localparam logic [5:0] REG_WAKE_THR = 6'h21;
    localparam logic [5:0] REG_STATUS = 6'h22;
    localparam logic [5:0] REG_ANGLE = 6'h23;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SCALE_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    localparam logic [11:0] COEF_RESET = 12'h000;
    // 53 steps per window: 100 rpm gives about 54.6 steps per ms
    localparam logic [15:0] WAKE_THR_RESET = 16'h0035;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 20000;
    localparam int WAKE_WINDOW_US = 1000;
    localparam int WAKE_WINDOW_CYCLES = WAKE_WINDOW_US * CLK_KHZ / 1000;

    // ------------------------------------------------------------
    // wake states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ALI_SLEEP = 2'b01,
        ALI_AWAKE = 2'b10
    } ali_wake_t;

endpackage : ali_pkg

/* File: rtl/ali_interp.sv */
`timescale 1ns/10ps
module ali_interp (
    input wire logic signed [11:0] coef_lo,
    input wire logic signed [11:0] coef_hi,
    input wire logic [9:0] frac,
    input wire logic scale_sel,
    output logic signed [13:0] corr
);

    // ------------------------------------------------------------
    // linear blend of two neighbouring coefficients
    // ------------------------------------------------------------
    logic signed [12:0] diff;
    logic signed [23:0] prod;
    logic signed [12:0] blend;

    // floor shift keeps frac 0 exactly on the low coefficient
    assign diff = 13'(coef_hi) - 13'(coef_lo);
    assign prod = diff * $signed({1'b0, frac});
    assign blend = 13'(coef_lo) + prod[22:10];

    // doubled range shifts the step up by one bit
    assign corr = scale_sel ? {blend, 1'b0} : 14'(blend);

endmodule : ali_interp

/* File: rtl/ali_wake.sv */
`timescale 1ns/10ps
module ali_wake #(
    parameter int WINDOW_CYCLES = ali_pkg::WAKE_WINDOW_CYCLES
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [14:0] raw_angle,
    input wire logic raw_valid,
    input wire logic low_power,
    input wire logic [15:0] rate_thr,
    output logic awake
);

    if (WINDOW_CYCLES < 2) begin : g_bad_window
        $error("wake window must be at least two cycles");
    end

    // ------------------------------------------------------------
    // window divider and raw angle tracking
    // ------------------------------------------------------------
    logic [31:0] win_cnt;
    logic tick;
    logic [14:0] cur;
    logic [14:0] ref_angle;
    logic [14:0] delta;
    logic [14:0] mag;
    logic fast;
    ali_pkg::ali_wake_t state;
    ali_pkg::ali_wake_t next_state;

    assign tick = (win_cnt == 32'(WINDOW_CYCLES - 1));
    // raw angle only: corrected angle never enters this path
    assign delta = cur - ref_angle;
    assign mag = delta[14] ? 15'(-delta) : delta;
    assign fast = {1'b0, mag} > rate_thr;

    // divider, one tick per window
    always_ff @(posedge clk) begin
        if (!resetn || tick) begin
            win_cnt <= 32'h0;
        end else begin
            win_cnt <= win_cnt + 32'h1;
        end
    end

    // latest raw sample and the sample at the last tick
    always_ff @(posedge clk) begin
        if (!resetn) begin
            cur <= 15'h0000;
            ref_angle <= 15'h0000;
        end else begin
            if (raw_valid) begin
                cur <= raw_angle;
            end
            if (tick) begin
                ref_angle <= cur;
            end
        end
    end

    // in low power the decision falls only at window ends, so slow drift never wakes
    always_comb begin
        next_state = state;
        unique case (state)
            ali_pkg::ALI_SLEEP: begin
                if (!low_power || (tick && fast)) begin
                    next_state = ali_pkg::ALI_AWAKE;
                end
            end
            ali_pkg::ALI_AWAKE: begin
                if (low_power && tick && !fast) begin
                    next_state = ali_pkg::ALI_SLEEP;
                end
            end
            default: next_state = ali_pkg::ALI_AWAKE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= ali_pkg::ALI_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    assign awake = (state == ali_pkg::ALI_AWAKE);

endmodule : ali_wake

/* File: rtl/ali_angle_linearizer.sv */
// Our own choices: the address map and the plain strobed port.
`timescale 1ns/10ps
// Summary of operation
// - 32 coefficients, coefficient k at k times 11.25 degrees.
// - on a breakpoint the output is the angle minus its coefficient.
// - coefficients are 12-bit two's-complement, -2048 to 2047.
// - scale bit clear maps the span to +22.50 down to -22.49 degrees.
// - scale bit set doubles it to +45.00 down to -44.98 degrees.
// - between breakpoints the correction is linearly interpolated.
// - latency is the same with the correction on or bypassed.
// - with correction off the coefficients are plain user storage.
// - the low-power tracking path uses the raw angle only.
// - low-power wake comes from the raw angle change rate.
// - default wake rate keeps the device awake above 100 rpm.
module ali_angle_linearizer #(
    parameter int WAKE_WINDOW_CYCLES = ali_pkg::WAKE_WINDOW_CYCLES
) (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic [14:0] ANGLE_IN,
    input wire logic ANGLE_IN_VALID,
    input wire logic LOW_POWER,
    input wire logic [5:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    output logic [15:0] RDATA,
    output logic [14:0] ANGLE_OUT,
    output logic ANGLE_OUT_VALID,
    output logic AWAKE
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    // the interpolation split assumes 32 segments of 1024 steps
    if (ali_pkg::SEG_W + ali_pkg::FRAC_W != ali_pkg::ANGLE_W) begin : g_bad
        $error("segment and fraction widths must fill the angle");
    end
    if ((1 << ali_pkg::SEG_W) != ali_pkg::NUM_COEF) begin : g_bad_seg
        $error("coefficient count must match the segment field");
    end
    // ports are cut for a 15-bit angle and a 10-bit fraction
    if (ali_pkg::ANGLE_W != 15) begin : g_bad_angle
        $error("angle ports are built for 15-bit angles");
    end
    if (ali_pkg::FRAC_W != 10) begin : g_bad_frac
        $error("blend port is built for a 10-bit fraction");
    end
    // storage and blend ports are cut for 12-bit coefficients
    if (ali_pkg::COEF_W != 12) begin : g_bad_coef
        $error("coefficient storage is built for 12-bit words");
    end
    // doubled range needs one bit above the sign of the blend
    if (ali_pkg::CORR_W != ali_pkg::COEF_W + 2) begin : g_bad_corr
        $error("correction must be two bits wider than a coefficient");
    end
    // coefficients must stay below the control words in the map
    if (ali_pkg::NUM_COEF > int'(ali_pkg::REG_CTRL)) begin : g_bad_map
        $error("coefficient words overlap the control words");
    end
    // angle readback needs a data word wider than the angle
    if (ali_pkg::DATA_W <= ali_pkg::ANGLE_W) begin : g_bad_data
        $error("data word too narrow for the angle readback");
    end
    // decode compares full 6-bit word addresses
    if (ali_pkg::ADDR_W != 6) begin : g_bad_addr
        $error("address decode is built for 6-bit word addresses");
    end
    // the divider ticks every cycle or never with a window under two cycles
    if (WAKE_WINDOW_CYCLES < 2) begin : g_bad_window
        $error("wake window must be at least two cycles");
    end

    // ------------------------------------------------------------
    // angle format
    // ------------------------------------------------------------
    // 2**15 steps per revolution, about 0.011 degrees a step
    // top five bits: one of 32 segments of 11.25 degrees
    // low ten bits: the place inside that segment
    // coefficient lsb: one step, or two at the doubled range
    // a 12-bit coefficient reaches 22.5 degrees, 45 when doubled
    // all sums wrap modulo one revolution, nothing is clamped
    // the blend floors, so it may sit one step under the line
    // controls ride with each sample through the pipe

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    // stored coefficients and controls
    logic [11:0] corr_coef [0:ali_pkg::NUM_COEF-1];
    logic corr_en;
    logic corr_scale_sel;
    logic [15:0] wake_thr;

    // angle split and the neighbour pair
    logic [4:0] seg;
    logic [4:0] seg_next;
    logic [9:0] frac;
    logic [11:0] pick_lo;
    logic [11:0] pick_hi;

    // stage one register
    logic s1_valid;
    logic [14:0] s1_angle;
    logic [11:0] s1_lo;
    logic [11:0] s1_hi;
    logic [9:0] s1_frac;
    logic s1_en;
    logic s1_scale;

    // stage two
    logic signed [13:0] corr;
    logic [14:0] corr_ext;
    logic [14:0] next_angle;

    // bus decode, write strobes and read words
    logic [4:0] coef_idx;
    logic hit_coef;
    logic hit_ctrl;
    logic hit_thr;
    logic hit_status;
    logic hit_angle;
    logic coef_we;
    logic ctrl_we;
    logic thr_we;
    logic [15:0] next_rdata;
    logic [15:0] rd_coef;
    logic [15:0] rd_ctrl;
    logic [15:0] rd_thr;
    logic [15:0] rd_status;
    logic [15:0] rd_angle;

    // ------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------
    // coefficients fill the lowest 32 words of the map
    assign coef_idx = ADDR[4:0];
    assign hit_coef = (ADDR <= ali_pkg::REG_COEF_LAST);
    assign hit_ctrl = (ADDR == ali_pkg::REG_CTRL);
    assign hit_thr = (ADDR == ali_pkg::REG_WAKE_THR);
    assign hit_status = (ADDR == ali_pkg::REG_STATUS);
    assign hit_angle = (ADDR == ali_pkg::REG_ANGLE);

    // write strobes per register group
    assign coef_we = WR_EN && hit_coef;
    assign ctrl_we = WR_EN && hit_ctrl;
    assign thr_we = WR_EN && hit_thr;

    // ------------------------------------------------------------
    // coefficient storage
    // ------------------------------------------------------------
    // always writable and readable, so with the correction off the
    // words serve as user storage and nothing else looks at them
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            for (int i = 0; i < ali_pkg::NUM_COEF; i++) begin
                corr_coef[i] <= ali_pkg::COEF_RESET;
            end
        end else if (coef_we) begin
            corr_coef[coef_idx] <= WDATA[11:0];
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // enable and range bits, then the wake rate limit
    // a sample already in flight keeps the bits it was taken with
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            corr_en <= ali_pkg::CTRL_RESET[ali_pkg::CTRL_EN_BIT];
            corr_scale_sel <= ali_pkg::CTRL_RESET[ali_pkg::CTRL_SCALE_BIT];
        end else if (ctrl_we) begin
            corr_en <= WDATA[ali_pkg::CTRL_EN_BIT];
            corr_scale_sel <= WDATA[ali_pkg::CTRL_SCALE_BIT];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            wake_thr <= ali_pkg::WAKE_THR_RESET;
        end else if (thr_we) begin
            wake_thr <= WDATA;
        end
    end

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // each word zero-filled above its field
    assign rd_coef = {4'h0, corr_coef[coef_idx]};
    assign rd_ctrl = {14'h0000, corr_scale_sel, corr_en};
    assign rd_thr = wake_thr;
    assign rd_status = {15'h0000, AWAKE};
    assign rd_angle = {1'b0, ANGLE_OUT};

    // unmapped words read zero; data stand one cycle after the strobe
    always_comb begin
        next_rdata = 16'h0000;
        if (hit_coef) begin
            next_rdata = rd_coef;
        end else if (hit_ctrl) begin
            next_rdata = rd_ctrl;
        end else if (hit_thr) begin
            next_rdata = rd_thr;
        end else if (hit_status) begin
            next_rdata = rd_status;
        end else if (hit_angle) begin
            next_rdata = rd_angle;
        end
    end

    // zero between reads, so a stale word never passes as fresh
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            RDATA <= 16'h0000;
        end else if (RD_EN) begin
            RDATA <= next_rdata;
        end else begin
            RDATA <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // stage one: pick the two neighbouring coefficients
    // ------------------------------------------------------------
    // top bits give the breakpoint, low bits the place inside it
    assign seg = ANGLE_IN[14:10];
    assign frac = ANGLE_IN[9:0];
    // last segment blends back to the first coefficient
    assign seg_next = seg + 5'h01;
    // neighbour pair read straight from the table
    assign pick_lo = corr_coef[seg];
    assign pick_hi = corr_coef[seg_next];

    // controls are taken with the sample, as the angle is
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            s1_valid <= 1'b0;
            s1_angle <= 15'h0000;
            s1_lo <= 12'h000;
            s1_hi <= 12'h000;
            s1_frac <= 10'h000;
            s1_en <= 1'b0;
            s1_scale <= 1'b0;
        end else begin
            s1_valid <= ANGLE_IN_VALID;
            if (ANGLE_IN_VALID) begin
                s1_angle <= ANGLE_IN;
                s1_lo <= pick_lo;
                s1_hi <= pick_hi;
                s1_frac <= frac;
                s1_en <= corr_en;
                s1_scale <= corr_scale_sel;
            end
        end
    end

    // ------------------------------------------------------------
    // stage two: blend and subtract
    // ------------------------------------------------------------
    ali_interp u_interp (
        .coef_lo(s1_lo),
        .coef_hi(s1_hi),
        .frac(s1_frac),
        .scale_sel(s1_scale),
        .corr(corr)
    );

    // bypass only zeroes the correction; both paths share the same
    // two register stages, so enabling costs no latency
    assign corr_ext = s1_en ? {corr[13], corr} : 15'h0000;
    // modulo 2**15 arithmetic wraps the result into one revolution
    assign next_angle = s1_angle - corr_ext;

    // result and its valid move together at one edge
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            ANGLE_OUT <= 15'h0000;
            ANGLE_OUT_VALID <= 1'b0;
        end else begin
            ANGLE_OUT_VALID <= s1_valid;
            if (s1_valid) begin
                ANGLE_OUT <= next_angle;
            end
        end
    end

    // ------------------------------------------------------------
    // low-power rotation tracking
    // ------------------------------------------------------------
    // fed straight from the input, ahead of any correction
    // so the wake speed is counted in raw electrical steps
    ali_wake #(
        .WINDOW_CYCLES(WAKE_WINDOW_CYCLES)
    ) u_wake (
        .clk(SYS_CLK),
        .resetn(RESETN),
        .raw_angle(ANGLE_IN),
        .raw_valid(ANGLE_IN_VALID),
        .low_power(LOW_POWER),
        .rate_thr(wake_thr),
        .awake(AWAKE)
    );

endmodule : ali_angle_linearizer

/* File: sim/ali_angle_src.sv */
`timescale 1ns/10ps
// --------------------
// upstream angle source
// --------------------
module ali_angle_src (
    input wire logic clk,
    input wire logic req,
    input wire logic [14:0] req_angle,
    output logic [14:0] angle,
    output logic angle_valid
);
    logic [14:0] ang_q = 15'h0000;
    logic vld_q = 1'b0;
    // idle bus flips between the inverse of the last sample and the sample every cycle, so stale reads fail
    always_ff @(posedge clk) begin
        vld_q <= req;
        ang_q <= req ? req_angle : ~ang_q;
    end
    assign angle = ang_q;
    assign angle_valid = vld_q;
endmodule : ali_angle_src

/* File: sim/ali_angle_linearizer_assertions.sv */
`timescale 1ns/10ps
module ali_angle_linearizer_chk (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic [14:0] ANGLE_IN,
    input wire logic ANGLE_IN_VALID,
    input wire logic LOW_POWER,
    input wire logic [5:0] ADDR,
    input wire logic [15:0] WDATA,
    input wire logic WR_EN,
    input wire logic RD_EN,
    input wire logic [15:0] RDATA,
    input wire logic [14:0] ANGLE_OUT,
    input wire logic ANGLE_OUT_VALID,
    input wire logic AWAKE
);
    // --------------------
    // shadow of the enable bit
    // --------------------
    logic corr_on;
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            corr_on <= 1'b0;
        end else if (WR_EN && ADDR == ali_pkg::REG_CTRL) begin
            corr_on <= WDATA[ali_pkg::CTRL_EN_BIT];
        end
    end
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    out_latency_a: assert property (
        ANGLE_IN_VALID |-> ##2 ANGLE_OUT_VALID)
        else $error("output valid late or missing");
    out_cause_a: assert property (
        ANGLE_OUT_VALID |-> $past(ANGLE_IN_VALID, 2))
        else $error("output valid without input");
    out_hold_a: assert property (
        !ANGLE_OUT_VALID |-> $stable(ANGLE_OUT))
        else $error("output angle moved without valid");
    bypass_pass_a: assert property (
        ANGLE_IN_VALID && !corr_on && !WR_EN
        |-> ##2 ANGLE_OUT == $past(ANGLE_IN, 2))
        else $error("bypassed angle altered");
    rdata_idle_a: assert property (
        !$past(RD_EN) |-> RDATA == 16'h0000)
        else $error("read data outside read cycle");
    coef_width_a: assert property (
        RD_EN && ADDR <= ali_pkg::REG_COEF_LAST |=> RDATA[15:12] == 4'h0)
        else $error("coefficient wider than 12 bits");
    unmapped_read_a: assert property (
        RD_EN && ADDR > ali_pkg::REG_ANGLE |=> RDATA == 16'h0000)
        else $error("unmapped read not zero");
    awake_active_a: assert property (
        !LOW_POWER |=> AWAKE)
        else $error("asleep outside low power");
    sleep_cause_a: assert property (
        $fell(AWAKE) |-> $past(LOW_POWER))
        else $error("fell asleep outside low power");
endmodule : ali_angle_linearizer_chk

bind ali_angle_linearizer ali_angle_linearizer_chk chk_u (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .ANGLE_IN(ANGLE_IN),
    .ANGLE_IN_VALID(ANGLE_IN_VALID), .LOW_POWER(LOW_POWER), .ADDR(ADDR),
    .WDATA(WDATA), .WR_EN(WR_EN), .RD_EN(RD_EN), .RDATA(RDATA),
    .ANGLE_OUT(ANGLE_OUT), .ANGLE_OUT_VALID(ANGLE_OUT_VALID), .AWAKE(AWAKE));

/* File: sim/tb.sv */
`timescale 1ns/10ps
module tb;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic low_power = 1'b0;
    logic [5:0] addr = 6'h00;
    logic [15:0] wdata = 16'h0000;
    logic wr_en = 1'b0;
    logic rd_en = 1'b0;
    logic src_req = 1'b0;
    logic [14:0] src_ang = 15'h0000;
    logic [14:0] ang_in, ang_out;
    logic ang_in_vld, ang_out_vld, awake;
    logic [15:0] rdata;
    logic [11:0] coef_tab [32];
    logic [14:0] last_e;
    int err_total = 0;
    int num_checks = 0;
    int cyc = 0;
    always #25 clk = ~clk;
    ali_angle_src src_u (.clk(clk), .req(src_req), .req_angle(src_ang),
        .angle(ang_in), .angle_valid(ang_in_vld));
    // short wake window keeps the run brief
    ali_angle_linearizer #(.WAKE_WINDOW_CYCLES(16)) dut_u (
        .SYS_CLK(clk), .RESETN(resetn), .ANGLE_IN(ang_in),
        .ANGLE_IN_VALID(ang_in_vld), .LOW_POWER(low_power), .ADDR(addr),
        .WDATA(wdata), .WR_EN(wr_en), .RD_EN(rd_en), .RDATA(rdata),
        .ANGLE_OUT(ang_out), .ANGLE_OUT_VALID(ang_out_vld), .AWAKE(awake));
    // --------------------
    // access tasks
    // --------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [5:0] a, logic [15:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(logic [5:0] a, logic [15:0] exp, string what);
        @(posedge clk);
        rd_en <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 chk(what, rdata, exp);
    endtask : rd
    // expected: floor blend of neighbours, doubled at wide range, wrapped
    task automatic ang(logic [14:0] a, int sc, bit en);
        int lo, hi, b, n;
        logic [14:0] e;
        lo = $signed(coef_tab[a[14:10]]);
        hi = $signed(coef_tab[a[14:10] + 5'd1]);
        b = lo + (((hi - lo) * int'(a[9:0])) >>> 10);
        e = en ? a - 15'(b <<< sc) : a;
        last_e = e;
        @(posedge clk);
        src_req <= 1'b1;
        src_ang <= a;
        @(posedge clk);
        src_req <= 1'b0;
        for (n = 0; n < 6 && ang_out_vld !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk("angle valid", {15'h0, ang_out_vld}, 16'h0001);
        chk("angle latency", 16'(n), 16'h0002);
        chk("angle out", {1'b0, ang_out}, {1'b0, e});
    endtask : ang
    // raw angle advanced by a fixed step every cycle
    task automatic spin(logic [14:0] step);
        repeat (48) begin
            @(posedge clk);
            src_req <= 1'b1;
            src_ang <= src_ang + step;
        end
        @(posedge clk);
        src_req <= 1'b0;
        #1;
    endtask : spin
    // --------------------
    // test sequence
    // --------------------
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rd(ali_pkg::REG_CTRL, 16'h0000, "ctrl reset");
        rd(ali_pkg::REG_WAKE_THR, 16'h0035, "threshold reset");
        rd(ali_pkg::REG_COEF_LAST, 16'h0000, "coef reset");
        $display("test reset done");
        // both extremes of the signed range, then arbitrary values
        for (int k = 0; k < 32; k++) begin
            coef_tab[k] = k == 0 ? 12'h800 : k == 1 ? 12'h7ff : 12'(k * 173);
            wr(6'(k), {4'hf, coef_tab[k]});
        end
        for (int k = 0; k < 32; k++) begin
            rd(6'(k), {4'h0, coef_tab[k]}, "coef");
        end
        wr(6'h24, 16'hffff);
        rd(6'h24, 16'h0000, "unmapped");
        $display("test registers done");
        ang(15'h1234, 0, 0);
        ang(15'h0400, 0, 0);
        for (int sc = 0; sc < 2; sc++) begin
            wr(ali_pkg::REG_CTRL, 16'(1 + 2 * sc));
            for (int k = 0; k < 32; k++) begin
                ang(15'(k * 1024), sc, 1);
                ang(15'(k * 1044 + 300), sc, 1);
            end
        end
        rd(ali_pkg::REG_CTRL, 16'h0003, "ctrl");
        rd(ali_pkg::REG_ANGLE, {1'b0, last_e}, "angle reg");
        $display("test angle path done");
        // wake decision from raw steps: 48 per window slow, 64 fast
        @(posedge clk);
        low_power <= 1'b1;
        repeat (40) @(posedge clk);
        #1 chk("awake still", {15'h0, awake}, 16'h0000);
        spin(15'd3);
        chk("awake slow", {15'h0, awake}, 16'h0000);
        spin(15'd4);
        chk("awake fast", {15'h0, awake}, 16'h0001);
        rd(ali_pkg::REG_STATUS, 16'h0001, "status");
        // raised limit: the same fast spin no longer keeps it awake
        wr(ali_pkg::REG_WAKE_THR, 16'h0046);
        rd(ali_pkg::REG_WAKE_THR, 16'h0046, "threshold");
        spin(15'd4);
        chk("awake raised limit", {15'h0, awake}, 16'h0000);
        @(posedge clk);
        low_power <= 1'b0;
        $display("test wake done");
        wrap_up();
    end
    // hang guard well above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            wrap_up();
        end
    end
endmodule : tb
